// >>> rtl/glm_pkg.sv
package glm_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STEP_PULSE_MS = 250;
	localparam int unsigned STEP_PULSE_CYCLES = STEP_PULSE_MS * TICK_CYCLES;
	localparam int unsigned NUM_STEPS = 5;
	localparam int unsigned CFG_COUNT = 10;

	// Register byte offsets
	localparam logic [11:0] OFS_SHED_HIGH = 12'h000;
	localparam logic [11:0] OFS_SHED_LOW = 12'h004;
	localparam logic [11:0] OFS_ADD_DELAY = 12'h008;
	localparam logic [11:0] OFS_SUB_ADD_DELAY = 12'h00c;
	localparam logic [11:0] OFS_MULTI_ADD_LEVEL = 12'h010;
	localparam logic [11:0] OFS_MULTI_SUB_LEVEL = 12'h014;
	localparam logic [11:0] OFS_ADD_START_DELAY = 12'h018;
	localparam logic [11:0] OFS_ADD_WAIT_DELAY = 12'h01c;
	localparam logic [11:0] OFS_SUB_START_DELAY = 12'h020;
	localparam logic [11:0] OFS_SUB_WAIT_DELAY = 12'h024;
	localparam logic [11:0] OFS_STATUS = 12'h028;
	localparam logic [11:0] OFS_POWER = 12'h02c;

	// Configuration indices (offset / 4)
	localparam logic [3:0] IDX_SHED_HIGH = 4'h0;
	localparam logic [3:0] IDX_SHED_LOW = 4'h1;
	localparam logic [3:0] IDX_ADD_DELAY = 4'h2;
	localparam logic [3:0] IDX_SUB_ADD_DELAY = 4'h3;
	localparam logic [3:0] IDX_MULTI_ADD_LEVEL = 4'h4;
	localparam logic [3:0] IDX_MULTI_SUB_LEVEL = 4'h5;
	localparam logic [3:0] IDX_ADD_START_DELAY = 4'h6;
	localparam logic [3:0] IDX_ADD_WAIT_DELAY = 4'h7;
	localparam logic [3:0] IDX_SUB_START_DELAY = 4'h8;
	localparam logic [3:0] IDX_SUB_WAIT_DELAY = 4'h9;

	// Reset values, delays in milliseconds
	localparam logic [31:0] CFG_RESET [CFG_COUNT] = '{
		32'h0000_c000, 32'h0000_4000, 32'h0000_03e8, 32'h0000_03e8, 32'h0000_4000,
		32'h0000_c000, 32'h0000_07d0, 32'h0000_07d0, 32'h0000_07d0, 32'h0000_07d0};

	// Status field positions
	localparam int unsigned ST_SHED = 0;
	localparam int unsigned ST_DUMMY = 1;
	localparam int unsigned ST_ADD = 2;
	localparam int unsigned ST_SUB = 3;
	localparam int unsigned ST_STEPS_LSB = 4;
	localparam int unsigned ST_PULSE_LSB = 8;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_ADD = 2'b01,
		PS_SUB = 2'b10
	} glm_pulse_t;

	typedef struct packed {
		logic shed;
		logic dummy;
		logic load_add;
		logic load_sub;
		logic [NUM_STEPS-1:0] step_add;
		logic [NUM_STEPS-1:0] step_sub;
	} glm_out_t;

endpackage : glm_pkg

// >>> rtl/glm_top.sv
// How it works
// - Shed output on above high limit
// - Shed output off below low limit
// - Shedding always runs, output freely routable
// - Dummy-load output is inverse of shedding
// - Load-add active while below low limit
// - Load-subtract active while above high limit
// - Add delay between same-kind pulses
// - Subtract-add delay between opposite pulses
// - Held-off add fires only if still low
// - Five steps, add ascending, remove descending
// - Add step after add start delay
// - Add wait delay between add pulses
// - Remove step after subtract start delay
// - Subtract wait delay between subtract pulses
// - Step pulses last a quarter second
// - Further add needs start and wait
// - Expired wait: subtract after start only
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module glm_top #(
	parameter int unsigned POWER_W = 32,
	parameter int unsigned TICK_CYC = glm_pkg::TICK_CYCLES,
	parameter int unsigned PULSE_CYC = glm_pkg::STEP_PULSE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [POWER_W-1:0] power,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output glm_pkg::glm_out_t relays
);
	import glm_pkg::*;

	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic t);
		sat_inc = (t && v != 16'hffff) ? v + 16'h0001 : v;
	endfunction : sat_inc

	function automatic logic reached(input logic [15:0] elapsed, input logic [31:0] limit);
		reached = {16'h0000, elapsed} >= limit;
	endfunction : reached

	function automatic logic cfg_hit(input logic [11:0] addr);
		cfg_hit = (addr[11:6] == 6'h00) && (addr[5:2] < 4'(CFG_COUNT)) && (addr[1:0] == 2'b00);
	endfunction : cfg_hit

	logic [31:0] cfg [CFG_COUNT];
	logic [31:0] tick_cnt;
	logic tick;
	logic shed;
	logic load_add;
	logic load_sub;
	logic add_seen;
	logic sub_seen;
	logic [15:0] since_add;
	logic [15:0] since_sub;
	logic [15:0] m_add_start;
	logic [15:0] m_sub_start;
	logic [15:0] m_add_wait;
	logic [15:0] m_sub_wait;
	logic m_add_seen;
	logic m_sub_seen;
	logic [2:0] steps;
	logic [2:0] step_idx;
	logic [31:0] pulse_cnt;
	glm_pulse_t pstate;
	logic [NUM_STEPS-1:0] step_add;
	logic [NUM_STEPS-1:0] step_sub;
	logic aw_busy;
	logic w_busy;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	logic [POWER_W-1:0] shed_high;
	logic [POWER_W-1:0] shed_low;
	logic [POWER_W-1:0] m_add_level;
	logic [POWER_W-1:0] m_sub_level;
	logic above_high;
	logic below_low;
	logic add_gap_ok;
	logic sub_gap_ok;
	logic add_fire;
	logic sub_fire;
	logic m_add_cond;
	logic m_sub_cond;
	logic m_add_fire;
	logic m_sub_fire;
	logic pulse_done;
	logic wr_fire;
	logic [31:0] status;

	assign shed_high = cfg[IDX_SHED_HIGH][POWER_W-1:0];
	assign shed_low = cfg[IDX_SHED_LOW][POWER_W-1:0];
	assign m_add_level = cfg[IDX_MULTI_ADD_LEVEL][POWER_W-1:0];
	assign m_sub_level = cfg[IDX_MULTI_SUB_LEVEL][POWER_W-1:0];
	assign above_high = power > shed_high;
	assign below_low = power < shed_low;

	// Millisecond time base
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (tick_cnt >= TICK_CYC - 1) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end

	// Hysteretic shedding comparator, never gated
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shed <= 1'b0;
		end else if (above_high) begin
			shed <= 1'b1;
		end else if (below_low) begin
			shed <= 1'b0;
		end
	end

	// Pulse spacing checks for add and subtract outputs
	assign add_gap_ok = (!add_seen || reached(since_add, cfg[IDX_ADD_DELAY]))
		&& (!sub_seen || reached(since_sub, cfg[IDX_SUB_ADD_DELAY]));
	assign sub_gap_ok = (!sub_seen || reached(since_sub, cfg[IDX_ADD_DELAY]))
		&& (!add_seen || reached(since_add, cfg[IDX_SUB_ADD_DELAY]));
	assign add_fire = !load_add && below_low && add_gap_ok;
	assign sub_fire = !load_sub && above_high && sub_gap_ok;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_add <= 1'b0;
		end else if (add_fire) begin
			load_add <= 1'b1;
		end else if (!below_low) begin
			load_add <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_sub <= 1'b0;
		end else if (sub_fire) begin
			load_sub <= 1'b1;
		end else if (!above_high) begin
			load_sub <= 1'b0;
		end
	end

	// Elapsed time since last add and subtract pulse starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_add <= 16'h0000;
			since_sub <= 16'h0000;
			add_seen <= 1'b0;
			sub_seen <= 1'b0;
		end else begin
			since_add <= add_fire ? 16'h0000 : sat_inc(since_add, tick);
			since_sub <= sub_fire ? 16'h0000 : sat_inc(since_sub, tick);
			add_seen <= add_seen | add_fire;
			sub_seen <= sub_seen | sub_fire;
		end
	end

	// Five-step manager
	assign m_add_cond = (power < m_add_level) && (steps < 3'(NUM_STEPS));
	assign m_sub_cond = (power > m_sub_level) && (steps != 3'h0);
	assign m_sub_fire = (pstate == PS_IDLE) && m_sub_cond
		&& reached(m_sub_start, cfg[IDX_SUB_START_DELAY])
		&& (!m_sub_seen || reached(m_sub_wait, cfg[IDX_SUB_WAIT_DELAY]));
	assign m_add_fire = (pstate == PS_IDLE) && m_add_cond && !m_sub_fire
		&& reached(m_add_start, cfg[IDX_ADD_START_DELAY])
		&& (!m_add_seen || reached(m_add_wait, cfg[IDX_ADD_WAIT_DELAY]));
	assign pulse_done = pulse_cnt >= PULSE_CYC - 1;

	// Start timers restart when their condition drops or their own step fires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_add_start <= 16'h0000;
			m_sub_start <= 16'h0000;
		end else begin
			m_add_start <= (!m_add_cond || m_add_fire) ? 16'h0000 : sat_inc(m_add_start, tick);
			m_sub_start <= (!m_sub_cond || m_sub_fire) ? 16'h0000 : sat_inc(m_sub_start, tick);
		end
	end

	// Wait timers run from each step pulse start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_add_wait <= 16'h0000;
			m_sub_wait <= 16'h0000;
			m_add_seen <= 1'b0;
			m_sub_seen <= 1'b0;
		end else begin
			m_add_wait <= m_add_fire ? 16'h0000 : sat_inc(m_add_wait, tick);
			m_sub_wait <= m_sub_fire ? 16'h0000 : sat_inc(m_sub_wait, tick);
			m_add_seen <= m_add_seen | m_add_fire;
			m_sub_seen <= m_sub_seen | m_sub_fire;
		end
	end

	// Step pulse sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pstate <= PS_IDLE;
			pulse_cnt <= 32'h0000_0000;
			steps <= 3'h0;
			step_idx <= 3'h0;
		end else begin
			case (pstate)
				PS_IDLE: begin
					pulse_cnt <= 32'h0000_0000;
					if (m_sub_fire) begin
						pstate <= PS_SUB;
						step_idx <= steps - 3'h1;
						steps <= steps - 3'h1;
					end else if (m_add_fire) begin
						pstate <= PS_ADD;
						step_idx <= steps;
						steps <= steps + 3'h1;
					end
				end
				PS_ADD, PS_SUB: begin
					if (pulse_done) begin
						pstate <= PS_IDLE;
					end else begin
						pulse_cnt <= pulse_cnt + 32'h0000_0001;
					end
				end
				default: begin
					pstate <= PS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_add <= '0;
			step_sub <= '0;
		end else begin
			for (int i = 0; i < NUM_STEPS; i++) begin
				step_add[i] <= (pstate == PS_ADD) && (step_idx == 3'(i));
				step_sub[i] <= (pstate == PS_SUB) && (step_idx == 3'(i));
			end
		end
	end

	// Relay outputs toward load equipment
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relays <= '0;
		end else begin
			relays.shed <= shed;
			relays.dummy <= !shed;
			relays.load_add <= load_add;
			relays.load_sub <= load_sub;
			relays.step_add <= step_add;
			relays.step_sub <= step_sub;
		end
	end

	// Status word
	always_comb begin
		status = 32'h0000_0000;
		status[ST_SHED] = shed;
		status[ST_DUMMY] = !shed;
		status[ST_ADD] = load_add;
		status[ST_SUB] = load_sub;
		status[ST_STEPS_LSB +: 3] = steps;
		status[ST_PULSE_LSB +: 2] = pstate;
	end

	// AXI4-Lite write channels
	assign wr_fire = aw_busy && w_busy && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_busy <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_busy <= 1'b1;
			s_axi_awready <= 1'b0;
			aw_addr <= s_axi_awaddr;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				aw_busy <= 1'b0;
			end
			s_axi_awready <= !aw_busy;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_busy <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_busy <= 1'b1;
			s_axi_wready <= 1'b0;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				w_busy <= 1'b0;
			end
			s_axi_wready <= !w_busy;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (cfg_hit(aw_addr)) begin
				s_axi_bresp <= RESP_OKAY;
			end else if (aw_addr == OFS_STATUS || aw_addr == OFS_POWER) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers with byte enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CFG_COUNT; i++) begin
				cfg[i] <= CFG_RESET[i];
			end
		end else if (wr_fire && cfg_hit(aw_addr)) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					cfg[aw_addr[5:2]][8*b +: 8] <= w_data[8*b +: 8];
				end
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (cfg_hit(s_axi_araddr)) begin
				s_axi_rdata <= cfg[s_axi_araddr[5:2]];
				s_axi_rresp <= RESP_OKAY;
			end else if (s_axi_araddr == OFS_STATUS) begin
				s_axi_rdata <= status;
				s_axi_rresp <= RESP_OKAY;
			end else if (s_axi_araddr == OFS_POWER) begin
				s_axi_rdata <= 32'(power);
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_rvalid;
		end
	end

endmodule : glm_top

`default_nettype wire

// >>> test/glm_load_sys.sv
`timescale 1ns/1ps
`default_nettype none
module glm_load_sys (
	input wire logic aclk,
	input wire logic follow,
	input wire logic [31:0] base,
	input wire glm_pkg::glm_out_t relays,
	output logic [31:0] power
);
	import glm_pkg::*;
	logic [31:0] ofs = 32'h0;
	// Load moves only while asked to
	always @(posedge aclk) begin
		if (!follow) ofs <= 32'h0;
		else if (relays.load_add) ofs <= ofs + 32'h8;
		else if (relays.load_sub) ofs <= ofs - 32'h8;
	end
	assign power = base + ofs;
endmodule : glm_load_sys
`default_nettype wire

// >>> test/glm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module glm_chk #(
	parameter int unsigned PULSE_CYC = 50
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire glm_pkg::glm_out_t relays
);
	import glm_pkg::*;
	logic [31:0] hi_cnt;
	logic [2:0] nst;
	wire logic [9:0] st = {relays.step_add, relays.step_sub};
	always_ff @(posedge aclk) begin
		if (!aresetn || !(|st)) hi_cnt <= 32'h0;
		else hi_cnt <= hi_cnt + 32'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) nst <= 3'h0;
		else if ($rose(|relays.step_add)) nst <= nst + 3'h1;
		else if ($rose(|relays.step_sub)) nst <= nst - 3'h1;
	end
	chk_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(|st) |-> hi_cnt == PULSE_CYC) else $error("step pulse length wrong");
	chk_one_step: assert property (@(posedge aclk) disable iff (!aresetn)
		$onehot0(st)) else $error("two step outputs at once");
	chk_add_order: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(|relays.step_add) |-> relays.step_add == (5'h1 << nst)) else $error("step add order");
	chk_sub_order: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(|relays.step_sub) |-> relays.step_sub == (5'h1 << (nst - 3'h1))) else $error("step sub order");
	chk_dummy_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) && $past(aresetn, 2) |-> relays.dummy != relays.shed) else $error("dummy not inverse");
	chk_sub_shed: assert property (@(posedge aclk) disable iff (!aresetn)
		relays.load_sub |-> relays.shed) else $error("subtract without shed");
	chk_add_noshed: assert property (@(posedge aclk) disable iff (!aresetn)
		relays.load_add |-> !relays.shed) else $error("add while shed");
	chk_reset_quiet: assert property (@(posedge aclk)
		!aresetn |=> relays == '0) else $error("relays active in reset");
	chk_b_lat: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("late bvalid");
	chk_r_lat: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid) else $error("rvalid timing");
endmodule : glm_chk
bind glm_top glm_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .relays);
`default_nettype wire

// >>> test/glm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module glm_top_tb;
	import glm_pkg::*;
	localparam int TK = 10;
	localparam logic [31:0] CV [10] = '{1000, 500, 2, 4, 300, 2000, 3, 8, 3, 8};
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, follow;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, base, power, d;
	logic [31:0] pw = 32'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	glm_out_t relays, pr;
	int num_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int seed = 55511;
	int t_add = -9999, t_sub = -9999, t_sa = -9999, t_ss = -9999, t_lo = 0, t_hi = 0;
	int n_add = 0, n_sa = 0, n_ss = 0, es, p, c0;
	int pv [4] = '{1001, 1000, 499, 500};
	always #10 aclk = ~aclk;
	glm_top #(.TICK_CYC(TK), .PULSE_CYC(50)) u_dut (.aclk, .aresetn, .power, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .relays);
	glm_load_sys u_load (.aclk, .follow, .base, .relays, .power);
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic ok(input string s, input logic c);
		chk(s, 32'h1, {31'h0, c});
	endtask : ok
	task automatic tmo();
		num_errors++;
		$display("BAD wait exp event got none");
		end_of_test();
	endtask : tmo
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 99);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 99) tmo();
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 99);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 99) tmo();
	endtask : rd
	task automatic wt(input int w);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (((w[1] ? relays.load_sub : relays.load_add) ^ w[0]) !== 1'b1 && n < 300);
		if (n >= 300) tmo();
	endtask : wt
	task automatic wn(input logic k, input int v);
		int n;
		n = 0;
		while ((k ? n_ss : n_sa) < v && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 3000) tmo();
	endtask : wn
	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		base <= 32'h8000;
		repeat (10) @(posedge aclk);
		chk("reset relays", 32'h0, relays);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(OFS_STATUS);
		chk("status", 32'h2, d);
		base <= 32'd700;
		for (int i = 0; i < 10; i++) begin
			rd(12'(4 * i));
			chk("cfg reset", CFG_RESET[i], d);
			wr(12'(4 * i), CV[i]);
			chk("wresp", {30'h0, RESP_OKAY}, {30'h0, r});
			rd(12'(4 * i));
			chk("cfg", CV[i], d);
		end
	endtask : rst
	// Spacing watch on every pulse
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		pr <= relays;
		pw <= power;
		if (power < CV[4] && !(pw < CV[4])) t_lo <= cyc;
		if (power > CV[5] && !(pw > CV[5])) t_hi <= cyc;
		if (relays.load_add && !pr.load_add) begin
			ok("add gap", cyc - t_add >= (CV[2] - 1) * TK);
			ok("sub add gap", cyc - t_sub >= (CV[3] - 1) * TK);
			t_add <= cyc;
			n_add <= n_add + 1;
		end
		if (relays.load_sub && !pr.load_sub) begin
			ok("sub gap", cyc - t_sub >= (CV[2] - 1) * TK);
			ok("add sub gap", cyc - t_add >= (CV[3] - 1) * TK);
			t_sub <= cyc;
		end
		if (|relays.step_add && !(|pr.step_add)) begin
			ok("step add wait", cyc - t_sa >= (CV[7] - 1) * TK);
			ok("step add start", cyc - t_lo >= (CV[6] - 1) * TK);
			t_sa <= cyc;
			n_sa <= n_sa + 1;
		end
		if (|relays.step_sub && !(|pr.step_sub)) begin
			ok("step sub wait", cyc - t_ss >= (CV[9] - 1) * TK);
			ok("step sub start", cyc - t_hi >= (CV[8] - 1) * TK);
			t_ss <= cyc;
			n_ss <= n_ss + 1;
		end
		if (!aresetn) begin
			n_sa <= 0;
			n_ss <= 0;
		end
	end
	initial begin
		{aresetn, follow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		base = 32'h8000;
		rst();
		rd(12'h030);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(12'h030, 32'h1);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
		es = 0;
		for (int i = 0; i < 24; i++) begin
			p = (i < 4) ? pv[i] : $unsigned($random(seed)) % 1500;
			@(posedge aclk);
			base <= p;
			repeat (70) @(posedge aclk);
			es = (p > CV[0]) ? 1 : (p < CV[1]) ? 0 : es;
			chk("shed", es, relays.shed);
			chk("dummy", !es, relays.dummy);
			chk("load add", p < CV[1], relays.load_add);
			chk("load sub", p > CV[0], relays.load_sub);
		end
		follow <= 1'b1;
		base <= 32'd100;
		wt(0);
		wt(1);
		ok("raised load", power >= CV[1]);
		base <= 32'd1500;
		wt(2);
		wt(3);
		ok("lowered load", power <= CV[0]);
		follow <= 1'b0;
		wt(2);
		c0 = n_add;
		base <= 32'd100;
		repeat (15) @(posedge aclk);
		base <= 32'd700;
		repeat (60) @(posedge aclk);
		chk("held off add", c0, n_add);
		base <= 32'd100;
		wt(0);
		base <= 32'd700;
		rst();
		for (int i = 0; i < 4; i++) begin
			base <= 32'd100;
			repeat (15) @(posedge aclk);
			base <= 32'd700;
			repeat (5) @(posedge aclk);
		end
		chk("early step", 0, n_sa);
		base <= 32'd100;
		wn(0, 5);
		repeat (200) @(posedge aclk);
		chk("full steps", 5, n_sa);
		rd(OFS_STATUS);
		chk("steps", 5, d[6:4]);
		base <= 32'd3000;
		wn(1, 2);
		base <= 32'd700;
		repeat (200) @(posedge aclk);
		c0 = cyc;
		base <= 32'd3000;
		wn(1, 3);
		ok("sub start only", t_ss - c0 <= (CV[8] + 1) * TK + 8);
		wn(1, 5);
		repeat (200) @(posedge aclk);
		chk("empty steps", 5, n_ss);
		rd(OFS_STATUS);
		chk("steps", 0, d[6:4]);
		end_of_test();
	end
endmodule : glm_top_tb
`default_nettype wire
